// [common/exec_map.svh]
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OPC_REG_CLASS 6'h00
`define OPC_IMM_CLASS 6'h01
`define OPC_XOR_IMM 6'h0E
`define OPC_SYS_COP 6'h10
`define OPC_FLT_COP 6'h11
`define OPC_EXT_CLASS 6'h1F
`define FN_TRAP_NE 6'h36
`define FN_XOR 6'h26
`define FN_FP_TRUNCATE_TO_LONG 6'h09
`define FN_FP_TRUNCATE_TO_WORD 6'h0D
`define FN_BYTE_SHUF 6'h20
`define FN_WAIT 6'h20
`define SEL_TRAP_NE_IMM 5'h0E
`define SEL_SWAP_HALF 5'h02
`define SUB_WR_PREV 5'h0E
`define SUB_WAIT_CO 1'h1
`define FMT_SINGLE 5'h10
`define FMT_DOUBLE 5'h11
`define LONG_MAX 64'h7FFFFFFFFFFFFFFF
`define WORD_MAX 64'h000000007FFFFFFF
`define SHADOW_SETS 4
`define SHADOW_REGS 32
`endif

// [common/exec_pkg.sv]
package exec_pkg;
	typedef enum logic [1:0] {EXC_NONE, EXC_TRAP, EXC_INVALID, EXC_OTHER} exc_kind_e;
	typedef enum {RUN, STANDBY} power_state_e;
	typedef logic [63:0] dword_t;
endpackage

// [src/fp_truncate.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
// Truncates a single or double value toward zero into a 64-bit or 32-bit integer.
module fp_truncate
	import exec_pkg::*;
(
	input wire logic [63:0] srcBits,
	input wire logic isDouble,
	input wire logic toWord,
	output dword_t result,
	output logic invalid
);
	logic [10:0] expo;
	logic [52:0] mant;
	logic sign;
	logic register_class_opcode;
	logic [11:0] shift;
	logic [116:0] wide;
	logic [63:0] mag;
	logic ovf;
	always_comb begin
		if (isDouble) begin
			sign = srcBits[63];
			expo = srcBits[62:52];
			mant = {(expo != 11'h000), srcBits[51:0]};
			register_class_opcode = (expo == 11'h7FF);
			shift = {1'b0, expo} - 12'h3FF;
		end else begin
			sign = srcBits[31];
			expo = {3'h0, srcBits[30:23]};
			mant = {(expo != 11'h000), srcBits[22:0], 29'h0};
			register_class_opcode = (expo == 11'h0FF);
			shift = {1'b0, expo} - 12'h07F;
		end
		wide = '0;
		ovf = 1'b0;
		if (shift[11]) begin
			mag = '0;
		end else if (shift > 12'h03F) begin
			mag = '0;
			ovf = 1'b1;
		end else begin
			wide = {64'h0, mant} << shift[5:0];
			mag = wide[115:52];
			ovf = (wide[116] != 1'b0);
		end
		if (toWord) begin
			ovf = ovf || (sign ? (mag > 64'h80000000) : (mag > 64'h7FFFFFFF));
		end else begin
			ovf = ovf || mag[63] && !(sign && mag == 64'h8000000000000000);
		end
		invalid = register_class_opcode || ovf;
		result = sign ? (64'h0 - mag) : mag;
		if (toWord) begin
			result = {32'h0, result[31:0]};
		end
	end
endmodule // fp_truncate

// [src/shadow_bank.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
// Shadow register sets; read data come out of a register.
module shadow_bank
	import exec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [1:0] wrSet,
	input wire logic [4:0] wrIdx,
	input wire dword_t wrData,
	input wire logic [1:0] rdSet,
	input wire logic [4:0] rdIdx,
	output dword_t rdData
);
	dword_t mem [`SHADOW_SETS * `SHADOW_REGS];
	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			mem[{wrSet, wrIdx}] <= wrData;
		end
		rdData <= mem[{rdSet, rdIdx}];
	end
endmodule // shadow_bank

// [src/trap_trunc_swap_xor_exec.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
// Function
// [RL1] Register not-equal trap on differing sources
// [RL2] Immediate not-equal trap, sign-extended immediate
// [RL3] Truncate float to 64-bit integer
// [RL4] 64-bit truncation invalid sets flag
// [RL5] Enabled invalid: no write, exception
// [RL6] Disabled invalid writes largest 64-bit
// [RL7] Truncate float to 32-bit integer
// [RL8] 32-bit truncation invalid: flag, trap
// [RL9] Disabled invalid writes largest 32-bit
// [RL10] Zero wait hint is default standby
// [RL11] Wait stalls, restarts after event
// [RL12] Reset or NMI restart standby
// [RL13] Interrupt taken after wait, next address
// [RL14] No wait in delay slot (not checked here; a wait is accepted wherever it is issued)
// [RL15] Wait without coprocessor access faults
// [RL16] Write to previous shadow set
// [RL17] Swap bytes in halfwords, sign-extend
// [RL18] Byte-swap source must be sign-extended
// [RL19] Register exclusive-or, no exception
// [RL20] Zero-extended immediate exclusive-or
// [RL21] Early release makes new encodings reserved
module trap_trunc_swap_xor_exec
	import exec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic issueValid,
	input wire logic [31:0] instrWord,
	input wire logic [63:0] instrPc,
	input wire dword_t firstSourceValue,
	input wire dword_t secondSourceValue,
	input wire dword_t floatSourceValue,
	input wire logic sysCopUsable,
	input wire logic floatCopUsable,
	input wire logic invalidEnable,
	input wire logic [1:0] previousSetField,
	input wire logic secondRevision,
	input wire logic intPending,
	input wire logic nmiPending,
	input wire logic [1:0] shadowRdSet,
	input wire logic [4:0] shadowRdIdx,
	output dword_t shadowRdData,
	output logic issueReady,
	output logic gprWrEn,
	output logic [4:0] gprWrIdx,
	output dword_t gprWrData,
	output logic fprWrEn,
	output logic [4:0] fprWrIdx,
	output dword_t fprWrData,
	output logic invalidFlag,
	output logic excValid,
	output exc_kind_e excKind,
	output logic [63:0] excReturnAddr,
	output logic standby,
	output logic waitHint
);
	logic [5:0] opc;
	logic [5:0] fn;
	logic [4:0] fieldA;
	logic [4:0] fieldB;
	logic [4:0] fieldC;
	logic [4:0] fieldD;
	dword_t immSext;
	dword_t immZext;
	logic isTrapReg;
	logic isTrapImm;
	logic isTruncL;
	logic isTruncW;
	logic isTrunc;
	logic isWrPrev;
	logic isSwap;
	logic isXor;
	logic isXorImm;
	logic isWait;
	logic reservedNew;
	logic trapHit;
	logic takeInstr;
	dword_t truncValue;
	logic truncInvalid;
	dword_t swapped;
	power_state_e state_reg;
	logic [63:0] resumePc_reg;

	assign opc = instrWord[31:26];
	assign fieldA = instrWord[25:21];
	assign fieldB = instrWord[20:16];
	assign fieldC = instrWord[15:11];
	assign fieldD = instrWord[10:6];
	assign fn = instrWord[5:0];
	assign immSext = {{48{instrWord[15]}}, instrWord[15:0]};
	assign immZext = {48'h0, instrWord[15:0]};

	assign isTrapReg = opc == `OPC_REG_CLASS && fn == `FN_TRAP_NE;
	assign isTrapImm = opc == `OPC_IMM_CLASS && fieldB == `SEL_TRAP_NE_IMM;
	assign isTruncL = opc == `OPC_FLT_COP && fn == `FN_FP_TRUNCATE_TO_LONG;
	assign isTruncW = opc == `OPC_FLT_COP && fn == `FN_FP_TRUNCATE_TO_WORD;
	assign isTrunc = isTruncL || isTruncW;
	assign isWrPrev = opc == `OPC_SYS_COP && fieldA == `SUB_WR_PREV;
	assign isSwap = opc == `OPC_EXT_CLASS && fn == `FN_BYTE_SHUF && fieldD == `SEL_SWAP_HALF;
	assign isXor = opc == `OPC_REG_CLASS && fn == `FN_XOR;
	assign isXorImm = opc == `OPC_XOR_IMM;
	assign isWait = opc == `OPC_SYS_COP && fieldA[4] == `SUB_WAIT_CO && fn == `FN_WAIT;
	assign reservedNew = !secondRevision && (isWrPrev || isSwap); // RL21
	assign trapHit = (isTrapReg && firstSourceValue != secondSourceValue) // RL1
		|| (isTrapImm && firstSourceValue != immSext); // RL2
	assign issueReady = state_reg == RUN; // RL11
	assign takeInstr = issueValid && issueReady;

	fp_truncate u_trunc (
		.srcBits(floatSourceValue),
		.isDouble(fieldA == `FMT_DOUBLE),
		.toWord(isTruncW),
		.result(truncValue),
		.invalid(truncInvalid)
	);

	// The source is assumed sign-extended; only the low word is used.
	assign swapped = {{32{secondSourceValue[23]}}, secondSourceValue[23:16], // RL17
		secondSourceValue[31:24], secondSourceValue[7:0], secondSourceValue[15:8]};

	shadow_bank u_shadow (
		.clk_sys(clk_sys),
		.wrEn(takeInstr && isWrPrev && sysCopUsable && !reservedNew), // RL16
		.wrSet(previousSetField),
		.wrIdx(fieldC),
		.wrData(secondSourceValue),
		.rdSet(shadowRdSet),
		.rdIdx(shadowRdIdx),
		.rdData(shadowRdData)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gprWrEn <= 1'b0;
			gprWrIdx <= 5'h00;
			gprWrData <= 64'h0;
		end else begin
			gprWrEn <= takeInstr && !reservedNew && (isSwap || isXor || isXorImm);
			gprWrIdx <= isXorImm ? fieldB : fieldC;
			if (isXorImm) begin
				gprWrData <= firstSourceValue ^ immZext; // RL20
			end else if (isXor) begin
				gprWrData <= firstSourceValue ^ secondSourceValue; // RL19
			end else begin
				gprWrData <= swapped; // RL17
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fprWrEn <= 1'b0;
			fprWrIdx <= 5'h00;
			fprWrData <= 64'h0;
		end else begin
			fprWrEn <= takeInstr && isTrunc && floatCopUsable
				&& !(truncInvalid && invalidEnable); // RL5
			fprWrIdx <= fieldD;
			if (truncInvalid) begin
				fprWrData <= isTruncW ? `WORD_MAX : `LONG_MAX; // RL6 RL9
			end else begin
				fprWrData <= truncValue; // RL3 RL7
			end
		end
	end

	// Sticky until reset; software clearing lives with the control register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			invalidFlag <= 1'b0;
		end else if (takeInstr && isTrunc && floatCopUsable && truncInvalid) begin
			invalidFlag <= 1'b1; // RL4 RL8
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= RUN;
			resumePc_reg <= 64'h0;
			waitHint <= 1'b0;
		end else begin
			unique case (state_reg)
				RUN: begin
					if (takeInstr && isWait && sysCopUsable) begin
						state_reg <= STANDBY; // RL11
						resumePc_reg <= instrPc + 64'h4;
						waitHint <= instrWord[24:6] != 19'h0; // RL10
					end
				end
				STANDBY: begin
					if (intPending || nmiPending) begin
						state_reg <= RUN; // RL12
					end
				end
			endcase
		end
	end
	assign standby = state_reg == STANDBY;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			excValid <= 1'b0;
			excKind <= EXC_NONE;
			excReturnAddr <= 64'h0;
		end else begin
			excValid <= 1'b0;
			excKind <= EXC_NONE;
			excReturnAddr <= instrPc;
			if (state_reg == STANDBY && (intPending || nmiPending)) begin
				excValid <= 1'b1; // RL12 RL13
				excKind <= EXC_OTHER;
				excReturnAddr <= resumePc_reg; // RL13
			end else if (takeInstr) begin
				if (reservedNew || ((isWait || isWrPrev) && !sysCopUsable)
					|| (isTrunc && !floatCopUsable)) begin
					excValid <= 1'b1; // RL15 RL21
					excKind <= EXC_OTHER;
				end else if (trapHit) begin
					excValid <= 1'b1; // RL1 RL2
					excKind <= EXC_TRAP;
				end else if (isTrunc && truncInvalid && invalidEnable) begin
					excValid <= 1'b1; // RL5 RL8
					excKind <= EXC_INVALID;
				end
			end
		end
	end

	property p_trap_reg;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isTrapReg && firstSourceValue != secondSourceValue
			|=> excValid && excKind == EXC_TRAP;
	endproperty
	a_trap_reg: assert property (p_trap_reg) else $error("reg trap missed"); // RL1
	property p_trap_imm;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isTrapImm && firstSourceValue == immSext |=> excKind != EXC_TRAP;
	endproperty
	a_trap_imm: assert property (p_trap_imm) else $error("false imm trap"); // RL2
	property p_inv_nowrite;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isTrunc && truncInvalid && invalidEnable |=> !fprWrEn && excValid;
	endproperty
	a_inv_nowrite: assert property (p_inv_nowrite) else $error("invalid wrote"); // RL5
	property p_inv_flag;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isTrunc && floatCopUsable && truncInvalid |=> invalidFlag;
	endproperty
	a_inv_flag: assert property (p_inv_flag) else $error("flag not set"); // RL4
	property p_default_word;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isTruncW && floatCopUsable && truncInvalid && !invalidEnable
			|=> fprWrEn && fprWrData == `WORD_MAX;
	endproperty
	a_default_word: assert property (p_default_word) else $error("bad default"); // RL9
	property p_stall;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isWait && sysCopUsable |=> standby && !issueReady;
	endproperty
	a_stall: assert property (p_stall) else $error("no standby"); // RL11
	property p_wake;
		@(posedge clk_sys) disable iff (rst)
		standby && nmiPending |=> !standby && excValid && excReturnAddr == $past(resumePc_reg);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // RL12
	property p_cop_unusable;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isWait && !sysCopUsable |=> !standby && excValid;
	endproperty
	a_cop_unusable: assert property (p_cop_unusable) else $error("wait allowed"); // RL15
	property p_xor;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isXor |=> gprWrEn && gprWrData == $past(firstSourceValue ^ secondSourceValue);
	endproperty
	a_xor: assert property (p_xor) else $error("xor wrong"); // RL19
	property p_reserved;
		@(posedge clk_sys) disable iff (rst)
		takeInstr && isSwap && !secondRevision |=> !gprWrEn && excKind == EXC_OTHER;
	endproperty
	a_reserved: assert property (p_reserved) else $error("not reserved"); // RL21
	c_standby: cover property (@(posedge clk_sys) standby ##[1:20] !standby);
	c_trap: cover property (@(posedge clk_sys) excKind == EXC_TRAP);
	c_invalid: cover property (@(posedge clk_sys) excKind == EXC_INVALID);
endmodule // trap_trunc_swap_xor_exec

// [sim/trap_trunc_swap_xor_exec_test.sv]
`timescale 1ns/1ps
module trap_trunc_swap_xor_exec_test
	import exec_pkg::*;
;
	localparam logic [31:0] xorWord = {6'h00, 5'h01, 5'h02, 5'h03, 5'h00, 6'h26};
	localparam logic [31:0] tneWord = {6'h00, 5'h01, 5'h02, 10'h000, 6'h36};
	localparam logic [31:0] tneiWord = {6'h01, 5'h01, 5'h0E, 16'hFFFF};
	localparam logic [31:0] swapWord = {6'h1F, 5'h00, 5'h02, 5'h04, 5'h02, 6'h20};
	localparam logic [31:0] prevWord = {6'h10, 5'h0E, 5'h03, 5'h07, 11'h000};
	localparam logic [31:0] waitWord = {6'h10, 1'b1, 19'h00000, 6'h20};
	logic clk_sys, rst, issueValid, sysCopUsable, floatCopUsable, invalidEnable;
	logic secondRevision, intPending, nmiPending;
	logic issueReady, gprWrEn, fprWrEn, invalidFlag, excValid, standby, waitHint;
	logic [31:0] instrWord;
	logic [63:0] instrPc, excReturnAddr, pcW;
	dword_t firstSourceValue, secondSourceValue, floatSourceValue;
	dword_t shadowRdData, gprWrData, fprWrData;
	logic [1:0] previousSetField, shadowRdSet;
	logic [4:0] shadowRdIdx, gprWrIdx, fprWrIdx;
	exc_kind_e excKind;
	int failures, n_tests, cycles;
	dword_t tSrc [8] = '{64'h4004000000000000, 64'hC3E0000000000000, 64'h43E0000000000000,
		64'h7FF8000000000000, 64'h00000000C0200000, 64'h00000000CF000000,
		64'h000000004F000000, 64'h7FF0000000000000};
	dword_t tRes [8] = '{64'h2, 64'h8000000000000000, 64'h7FFFFFFFFFFFFFFF,
		64'h7FFFFFFFFFFFFFFF, 64'h00000000FFFFFFFE, 64'h0000000080000000,
		64'h000000007FFFFFFF, 64'h000000007FFFFFFF};

	trap_trunc_swap_xor_exec u_dut (.clk_sys, .rst, .issueValid, .instrWord, .instrPc,
		.firstSourceValue, .secondSourceValue, .floatSourceValue, .sysCopUsable,
		.floatCopUsable, .invalidEnable, .previousSetField, .secondRevision, .intPending,
		.nmiPending, .shadowRdSet, .shadowRdIdx, .shadowRdData, .issueReady, .gprWrEn,
		.gprWrIdx, .gprWrData, .fprWrEn, .fprWrIdx, .fprWrData, .invalidFlag, .excValid,
		.excKind, .excReturnAddr, .standby, .waitHint);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chkb(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chkd(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic issue(input logic [31:0] w, input dword_t a, input dword_t b, input dword_t f);
		@(posedge clk_sys);
		issueValid <= 1'b1;
		instrWord <= w;
		instrPc <= instrPc + 64'h4;
		firstSourceValue <= a;
		secondSourceValue <= b;
		floatSourceValue <= f;
		@(posedge clk_sys);
		issueValid <= 1'b0;
		#1;
	endtask

	task automatic general_register(input logic [4:0] i, input dword_t d);
		chkb("gprWrEn", 1'b1, gprWrEn);
		chkd("gprWrIdx", {59'h0, i}, {59'h0, gprWrIdx});
		chkd("gprWrData", d, gprWrData);
		chkb("excValid", 1'b0, excValid);
	endtask

	task automatic exc(input exc_kind_e k);
		chkb("excValid", 1'b1, excValid);
		chkd("excKind", {62'h0, k}, {62'h0, excKind});
		chkb("anyWrEn", 1'b0, gprWrEn | fprWrEn);
	endtask

	task automatic tally_and_finish;
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Cuts a hung run short; the whole sequence needs well under two hundred cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			tally_and_finish();
		end
	end

	initial begin
		rst = 1'b1;
		issueValid = 1'b0;
		instrWord = 32'h00000000;
		instrPc = 64'h0000000000001000;
		firstSourceValue = 64'h0;
		secondSourceValue = 64'h0;
		floatSourceValue = 64'h0;
		sysCopUsable = 1'b1;
		floatCopUsable = 1'b1;
		invalidEnable = 1'b0;
		previousSetField = 2'h2;
		secondRevision = 1'b1;
		intPending = 1'b0;
		nmiPending = 1'b0;
		shadowRdSet = 2'h0;
		shadowRdIdx = 5'h00;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chkb("issueReady", 1'b1, issueReady);
		chkb("invalidFlag", 1'b0, invalidFlag);
		issue(xorWord, 64'hF0F0F0F0F0F0F0F0, 64'hFF00FF00FF00FF00, 64'h0);
		general_register(5'h03, 64'h0FF00FF00FF00FF0);
		issue({6'h0E, 5'h01, 5'h05, 16'h8001}, 64'hFFFFFFFFFFFFFFFF, 64'h0, 64'h0);
		general_register(5'h05, 64'hFFFFFFFFFFFF7FFE);
		issue(tneWord, 64'h1, 64'h8000000000000001, 64'h0);
		exc(EXC_TRAP);
		issue(tneWord, 64'h8000000000000001, 64'h8000000000000001, 64'h0);
		chkb("excValid", 1'b0, excValid);
		issue(tneiWord, 64'hFFFFFFFFFFFFFFFF, 64'h0, 64'h0);
		chkb("excValid", 1'b0, excValid);
		issue(tneiWord, 64'h000000000000FFFF, 64'h0, 64'h0);
		exc(EXC_TRAP);
		issue(swapWord, 64'h0, 64'hFFFFFFFF89ABCDEF, 64'h0);
		general_register(5'h04, 64'hFFFFFFFFAB89EFCD);
		issue(swapWord, 64'h0, 64'h000000007F8001FF, 64'h0);
		general_register(5'h04, 64'hFFFFFFFF807FFF01);
		issue(prevWord, 64'h0, 64'h0123456789ABCDEF, 64'h0);
		chkb("excValid", 1'b0, excValid);
		shadowRdSet <= 2'h2;
		shadowRdIdx <= 5'h07;
		@(posedge clk_sys);
		#1;
		chkd("shadowRdData", 64'h0123456789ABCDEF, shadowRdData);
		@(posedge clk_sys);
		secondRevision <= 1'b0;
		issue(swapWord, 64'h0, 64'h0000000012345678, 64'h0);
		exc(EXC_OTHER);
		issue(prevWord, 64'h0, 64'h1, 64'h0);
		exc(EXC_OTHER);
		secondRevision <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			issue({6'h11, (i < 4 || i == 7) ? 5'h11 : 5'h10, 5'h00, 5'h01, 5'h02,
				(i < 4) ? 6'h09 : 6'h0D}, 64'h0, 64'h0, tSrc[i]);
			chkb("fprWrEn", 1'b1, fprWrEn);
			chkd("fprWrIdx", 64'h2, {59'h0, fprWrIdx});
			chkd("fprWrData", tRes[i], fprWrData);
			chkb("invalidFlag", i >= 2, invalidFlag);
		end
		invalidEnable <= 1'b1;
		issue({6'h11, 5'h11, 5'h00, 5'h01, 5'h02, 6'h09}, 64'h0, 64'h0, 64'h7FF0000000000000);
		exc(EXC_INVALID);
		issue({6'h11, 5'h10, 5'h00, 5'h01, 5'h02, 6'h0D}, 64'h0, 64'h0, 64'h4F000000);
		exc(EXC_INVALID);
		for (int k = 0; k < 2; k++) begin
			issue(waitWord | {25'h0, k[0], 6'h00}, 64'h0, 64'h0, 64'h0);
			pcW = instrPc;
			chkb("standby", 1'b1, standby);
			chkb("issueReady", 1'b0, issueReady);
			chkb("waitHint", k[0], waitHint);
			issue(xorWord, 64'h1, 64'h2, 64'h0);
			chkb("gprWrEn", 1'b0, gprWrEn);
			@(posedge clk_sys);
			nmiPending <= (k == 0);
			intPending <= (k == 1);
			@(posedge clk_sys);
			nmiPending <= 1'b0;
			intPending <= 1'b0;
			#1;
			exc(EXC_OTHER);
			chkd("excReturnAddr", pcW + 64'h4, excReturnAddr);
			chkb("standby", 1'b0, standby);
		end
		sysCopUsable <= 1'b0;
		issue(waitWord, 64'h0, 64'h0, 64'h0);
		exc(EXC_OTHER);
		chkb("standby", 1'b0, standby);
		issue(prevWord, 64'h0, 64'h5, 64'h0);
		exc(EXC_OTHER);
		@(posedge clk_sys);
		#1;
		chkd("shadowRdData", 64'h0123456789ABCDEF, shadowRdData);
		floatCopUsable <= 1'b0;
		issue({6'h11, 5'h11, 5'h00, 5'h01, 5'h02, 6'h09}, 64'h0, 64'h0, 64'h4004000000000000);
		exc(EXC_OTHER);
		tally_and_finish();
	end
endmodule // trap_trunc_swap_xor_exec_test
